// [core/itu_regs.svh]
`ifndef ITU_REGS_SVH
`define ITU_REGS_SVH
// Address regions, paddr[11:8]
`define ITU_RGN_NODE 4'h0
`define ITU_RGN_SSR 4'h1
`define ITU_RGN_CH 4'h2
`define ITU_RGN_MISC 4'h3
// Offsets inside the misc region, paddr[7:0]
`define ITU_OFS_ERU_CFG 8'h00
`define ITU_OFS_ERU_STAT 8'h04
`define ITU_OFS_TRAP 8'h80
`define ITU_OFS_ESR 8'h84
`define ITU_OFS_CTRL 8'h88
// Word select inside a channel slot, paddr[3:2]
`define ITU_CH_CTL 2'h0
`define ITU_CH_SRC 2'h1
`define ITU_CH_DST 2'h2
// Node control fields
`define ITU_NC_REQ 0
`define ITU_NC_EN 1
`define ITU_NC_PRI 5:2
`define ITU_NC_MODE 6
`define ITU_NC_CH 9:7
// Channel control fields
`define ITU_CC_CNT 7:0
`define ITU_CC_WORD 8
`define ITU_CC_ISRC 9
`define ITU_CC_IDST 10
`define ITU_CC_CONT 11
// Control register fields
`define ITU_CTRL_JC 0
// Nodes fed by the output gates and by shared sources
`define ITU_NODE_ERU 6'h38
`define ITU_NODE_SH 6'h3C
// Least response, CPU clocks, with and without jump cache
`define ITU_RESP_JC 4'h7
`define ITU_RESP_NJC 4'hB
// Reset values
`define ITU_RST_NODE 10'h000
`define ITU_RST_CTL 12'h000
`define ITU_RST_PTR 16'h0000
`define ITU_RST_CFG 32'h0000_0000
`endif

// [core/itu_pkg.sv]
package itu_pkg;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WAIT = 2'b01,
		S_REQ = 2'b10,
		S_XFER = 2'b11
	} itu_state_e;
	typedef logic [9:0] itu_node_t;
endpackage

// [core/itu_eru_if.sv]
`timescale 1ns/1ns
interface itu_eru_if;
	logic [7:0] edge_sel;
	logic [7:0] route;
	logic [7:0] gate_mode;
	logic [3:0] mask;
	logic [3:0] gate_evt;
	logic [3:0] level;
	logic match;
	logic [2:0] esr_rise;
	modport core(output edge_sel, output route, output gate_mode, output mask,
		input gate_evt, input level, input match, input esr_rise);
	modport eru(input edge_sel, input route, input gate_mode, input mask,
		output gate_evt, output level, output match, output esr_rise);
endinterface

// [core/itu_eru.sv]
`timescale 1ns/1ns
`include "itu_regs.svh"
module itu_eru (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [3:0] eru_pin,
	input wire logic [2:0] esr_pin,
	itu_eru_if.eru bus
);
	logic [6:0] s1_reg, s2_reg, s3_reg;
	logic [3:0] gate_reg, gate_next;
	logic [2:0] esr_reg, esr_next;
	logic [6:0] rise, fall;
	logic [3:0] evt;
	logic [1:0] sel;
	logic match;

	always_comb begin
		rise = s2_reg & ~s3_reg;
		fall = ~s2_reg & s3_reg;
		match = &(s2_reg[3:0] | ~bus.mask);
		for (int c = 0; c < 4; c++) begin
			evt[c] = (rise[c] & bus.edge_sel[2*c]) | (fall[c] & bus.edge_sel[2*c+1]);
		end
		for (int g = 0; g < 4; g++) begin
			sel = bus.route[2*g +: 2];
			// 0 off, 1 pass, 2 pass on pattern match, 3 pass on miss
			unique case (bus.gate_mode[2*g +: 2])
				2'h0: gate_next[g] = 1'b0;
				2'h1: gate_next[g] = evt[sel];
				2'h2: gate_next[g] = evt[sel] & match;
				default: gate_next[g] = evt[sel] & ~match;
			endcase
		end
		esr_next = rise[6:4];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 7'h00;
			s2_reg <= 7'h00;
			s3_reg <= 7'h00;
			gate_reg <= 4'h0;
			esr_reg <= 3'h0;
		end else if (ce) begin
			s1_reg <= {esr_pin, eru_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			gate_reg <= gate_next;
			esr_reg <= esr_next;
		end
	end

	assign bus.gate_evt = gate_reg;
	assign bus.level = s2_reg[3:0];
	assign bus.match = match;
	assign bus.esr_rise = esr_reg;
endmodule

// [core/itu_top.sv]
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "itu_regs.svh"
// Functional notes
// - 64 nodes, each with flag, enable, priority
// - Shared nodes pick source by select register
// - Each node serviced vectored or by channel
// - Vectored service branches to node's vector
// - Channel service steals exactly one cycle
// - Move byte or word, bump chosen pointers
// - Counter decrements unless continuous mode
// - Zero counter raises vectored interrupt instead
// - Eight independent request-triggered transfer channels
// - Service starts no sooner than 7/11 clocks
// - Four inputs detect rising, falling, both
// - Routed events gated by pattern match/miss
// - Hardware trap vectors and sets flag bit
// - Trap preempts unless equal or higher trap active
// - Trap service blocks interrupts and transfers
// - Service pins feed two system request traps
// - Software writing request flag makes request
// - Software trap number enters that service
module itu_top #(
	parameter int CHANNELS = 8,
	parameter int PTR_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [63:0] src_evt,
	input wire logic [15:0] shared_src,
	input wire logic [3:0] eru_pin,
	input wire logic [2:0] esr_pin,
	input wire logic [7:0] hw_trap,
	input wire logic [3:0] cpu_level,
	output logic int_req,
	output logic [5:0] int_vector,
	output logic [3:0] int_level,
	input wire logic int_ack,
	output logic xfer_req,
	output logic [PTR_W-1:0] xfer_src,
	output logic [PTR_W-1:0] xfer_dst,
	output logic xfer_word,
	input wire logic xfer_ack,
	output logic trap_req,
	output logic [3:0] trap_vector,
	input wire logic trap_ack,
	input wire logic trap_done,
	input wire logic swtrap_valid,
	input wire logic [5:0] swtrap_num
);
	itu_pkg::itu_node_t node_reg [64];
	itu_pkg::itu_node_t node_next [64];
	logic [11:0] ctl_reg [CHANNELS];
	logic [11:0] ctl_next [CHANNELS];
	logic [PTR_W-1:0] src_reg [CHANNELS];
	logic [PTR_W-1:0] src_next [CHANNELS];
	logic [PTR_W-1:0] dst_reg [CHANNELS];
	logic [PTR_W-1:0] dst_next [CHANNELS];
	logic [31:0] eru_cfg_reg, eru_cfg_next;
	logic [7:0] ssr_reg, ssr_next;
	logic [7:0] esr_cfg_reg, esr_cfg_next;
	logic ctrl_reg, ctrl_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic [9:0] trap_flag_reg, trap_flag_next;
	logic [9:0] trap_pend_reg, trap_pend_next;
	logic [9:0] trap_act_reg, trap_act_next;
	logic trap_req_reg, trap_req_next;
	logic [3:0] trap_vec_reg, trap_vec_next;
	itu_pkg::itu_state_e state_reg, state_next;
	logic [5:0] sel_reg, sel_next;
	logic [3:0] lvl_reg, lvl_next;
	logic [3:0] cnt_reg, cnt_next;
	logic sw_reg, sw_next;
	logic swp_reg, swp_next;
	logic [5:0] swn_reg, swn_next;
	logic wr, setup, rd_ok, clr_en, xfer_take, trap_busy, best_ok, use_xfer;
	logic [31:0] rd_val;
	logic [63:0] evt;
	logic [9:0] trap_evt;
	logic [5:0] best_idx;
	logic [3:0] best_pri, resp_last;
	itu_pkg::itu_node_t sel_node;
	logic [2:0] ch_sel;
	logic [3:0] rgn;
	logic [5:0] widx;
	logic [2:0] wch;

	itu_eru_if eru_bus();

	itu_eru itu_eru_inst (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.eru_pin(eru_pin),
		.esr_pin(esr_pin),
		.bus(eru_bus)
	);

	function automatic logic [3:0] top_idx(input logic [9:0] v);
		top_idx = 4'h0;
		for (int k = 0; k < 10; k++) begin
			if (v[k]) top_idx = 4'(k);
		end
	endfunction

	function automatic logic [PTR_W-1:0] step(input logic word);
		step = word ? PTR_W'(2) : PTR_W'(1);
	endfunction

	assign eru_bus.edge_sel = eru_cfg_reg[7:0];
	assign eru_bus.route = eru_cfg_reg[15:8];
	assign eru_bus.gate_mode = eru_cfg_reg[23:16];
	assign eru_bus.mask = eru_cfg_reg[27:24];

	// Bus: read data captured in setup, so access phase has no wait state
	assign rgn = paddr[11:8];
	assign widx = paddr[7:2];
	assign wch = paddr[6:4];
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & ce;
	assign pready = ce;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok = 1'b0;
		case (rgn)
			`ITU_RGN_NODE: begin
				rd_ok = 1'b1;
				rd_val[9:0] = node_reg[widx];
			end
			`ITU_RGN_SSR: begin
				rd_ok = (paddr[7:0] == 8'h00);
				rd_val[7:0] = ssr_reg;
			end
			`ITU_RGN_CH: begin
				rd_ok = !paddr[7] && paddr[3:2] != 2'h3 && 32'(wch) < CHANNELS;
				case (paddr[3:2])
					`ITU_CH_CTL: rd_val[11:0] = ctl_reg[wch];
					`ITU_CH_SRC: rd_val[PTR_W-1:0] = src_reg[wch];
					`ITU_CH_DST: rd_val[PTR_W-1:0] = dst_reg[wch];
					default: rd_val = 32'h0000_0000;
				endcase
			end
			`ITU_RGN_MISC: begin
				rd_ok = 1'b1;
				case (paddr[7:0])
					`ITU_OFS_ERU_CFG: rd_val = eru_cfg_reg;
					`ITU_OFS_ERU_STAT: rd_val[4:0] = {eru_bus.match, eru_bus.level};
					`ITU_OFS_TRAP: rd_val[9:0] = trap_flag_reg;
					`ITU_OFS_ESR: rd_val[7:0] = esr_cfg_reg;
					`ITU_OFS_CTRL: rd_val[0] = ctrl_reg;
					default: rd_ok = 1'b0;
				endcase
			end
			default: rd_ok = 1'b0;
		endcase
		prdata_next = setup ? rd_val : prdata_reg;
		pslverr_next = setup ? !rd_ok : pslverr_reg;
	end

	always_comb begin
		eru_cfg_next = eru_cfg_reg;
		ssr_next = ssr_reg;
		esr_cfg_next = esr_cfg_reg;
		ctrl_next = ctrl_reg;
		if (wr && rgn == `ITU_RGN_SSR && paddr[7:0] == 8'h00) ssr_next = pwdata[7:0];
		if (wr && rgn == `ITU_RGN_MISC) begin
			if (paddr[7:0] == `ITU_OFS_ERU_CFG) eru_cfg_next = pwdata;
			if (paddr[7:0] == `ITU_OFS_ESR) esr_cfg_next = pwdata[7:0];
			if (paddr[7:0] == `ITU_OFS_CTRL) ctrl_next = pwdata[`ITU_CTRL_JC];
		end
	end

	// Request sources: dedicated, gated external events, shared nodes
	always_comb begin
		evt = src_evt;
		for (int g = 0; g < 4; g++) begin
			evt[32'(`ITU_NODE_ERU) + g] = src_evt[32'(`ITU_NODE_ERU) + g] | eru_bus.gate_evt[g];
			evt[32'(`ITU_NODE_SH) + g] = shared_src[g*4 + 32'(ssr_reg[2*g +: 2])];
		end
	end

	// Highest priority above the CPU level; ties go to the lowest node
	always_comb begin
		best_ok = 1'b0;
		best_idx = 6'h00;
		best_pri = 4'h0;
		for (int i = 0; i < 64; i++) begin
			if (node_reg[i][`ITU_NC_REQ] && node_reg[i][`ITU_NC_EN] &&
				node_reg[i][`ITU_NC_PRI] > cpu_level &&
				(!best_ok || node_reg[i][`ITU_NC_PRI] > best_pri)) begin
				best_ok = 1'b1;
				best_idx = 6'(i);
				best_pri = node_reg[i][`ITU_NC_PRI];
			end
		end
	end

	always_comb begin
		node_next = node_reg;
		if (wr && rgn == `ITU_RGN_NODE) node_next[widx] = pwdata[9:0];
		if (clr_en) node_next[sel_reg][`ITU_NC_REQ] = 1'b0;
		for (int i = 0; i < 64; i++) begin
			if (evt[i]) node_next[i][`ITU_NC_REQ] = 1'b1;
		end
	end

	assign sel_node = node_reg[sel_reg];
	assign ch_sel = sel_node[`ITU_NC_CH];
	assign resp_last = (ctrl_reg ? `ITU_RESP_JC : `ITU_RESP_NJC) - 4'h1;
	assign use_xfer = !sw_reg && sel_node[`ITU_NC_MODE] &&
		(ctl_reg[ch_sel][`ITU_CC_CONT] || ctl_reg[ch_sel][`ITU_CC_CNT] != 8'h00);
	assign trap_busy = |trap_act_reg;

	always_comb begin
		state_next = state_reg;
		sel_next = sel_reg;
		lvl_next = lvl_reg;
		cnt_next = cnt_reg;
		sw_next = sw_reg;
		swp_next = swp_reg | swtrap_valid;
		swn_next = swtrap_valid ? swtrap_num : swn_reg;
		clr_en = 1'b0;
		xfer_take = 1'b0;
		unique case (state_reg)
			itu_pkg::S_IDLE: begin
				if (!trap_busy && swp_reg) begin
					sel_next = swn_reg;
					sw_next = 1'b1;
					swp_next = swtrap_valid;
					lvl_next = cpu_level;
					cnt_next = 4'h0;
					state_next = itu_pkg::S_WAIT;
				end else if (!trap_busy && best_ok) begin
					sel_next = best_idx;
					sw_next = 1'b0;
					lvl_next = best_pri;
					cnt_next = 4'h0;
					state_next = itu_pkg::S_WAIT;
				end
			end
			itu_pkg::S_WAIT: begin
				cnt_next = cnt_reg + 4'h1;
				// A flag cleared by software meanwhile withdraws the request
				if (!sw_reg && !sel_node[`ITU_NC_REQ]) state_next = itu_pkg::S_IDLE;
				else if (cnt_reg == resp_last)
					state_next = use_xfer ? itu_pkg::S_XFER : itu_pkg::S_REQ;
			end
			itu_pkg::S_REQ: begin
				if (int_ack && !trap_busy) begin
					clr_en = !sw_reg;
					state_next = itu_pkg::S_IDLE;
				end
			end
			itu_pkg::S_XFER: begin
				if (xfer_ack && !trap_busy) begin
					clr_en = 1'b1;
					xfer_take = 1'b1;
					state_next = itu_pkg::S_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		ctl_next = ctl_reg;
		src_next = src_reg;
		dst_next = dst_reg;
		if (wr && rgn == `ITU_RGN_CH && !paddr[7] && 32'(wch) < CHANNELS) begin
			case (paddr[3:2])
				`ITU_CH_CTL: ctl_next[wch] = pwdata[11:0];
				`ITU_CH_SRC: src_next[wch] = pwdata[PTR_W-1:0];
				`ITU_CH_DST: dst_next[wch] = pwdata[PTR_W-1:0];
				default: ;
			endcase
		end
		if (xfer_take) begin
			if (ctl_reg[ch_sel][`ITU_CC_ISRC])
				src_next[ch_sel] = src_reg[ch_sel] + step(ctl_reg[ch_sel][`ITU_CC_WORD]);
			if (ctl_reg[ch_sel][`ITU_CC_IDST])
				dst_next[ch_sel] = dst_reg[ch_sel] + step(ctl_reg[ch_sel][`ITU_CC_WORD]);
			if (!ctl_reg[ch_sel][`ITU_CC_CONT])
				ctl_next[ch_sel][`ITU_CC_CNT] = ctl_reg[ch_sel][`ITU_CC_CNT] - 8'h01;
		end
	end

	// Traps: a higher index outranks a lower one
	always_comb begin
		trap_evt = {|(eru_bus.esr_rise & esr_cfg_reg[6:4]),
			|(eru_bus.esr_rise & esr_cfg_reg[2:0]), hw_trap};
		trap_flag_next = trap_flag_reg;
		if (wr && rgn == `ITU_RGN_MISC && paddr[7:0] == `ITU_OFS_TRAP)
			trap_flag_next = trap_flag_reg & ~pwdata[9:0];
		trap_flag_next = trap_flag_next | trap_evt;
		trap_pend_next = trap_pend_reg;
		trap_act_next = trap_act_reg;
		if (trap_done && trap_busy) trap_act_next[top_idx(trap_act_reg)] = 1'b0;
		if (trap_ack && trap_req_reg) begin
			trap_act_next[trap_vec_reg] = 1'b1;
			trap_pend_next[trap_vec_reg] = 1'b0;
		end
		trap_pend_next = trap_pend_next | trap_evt;
		trap_req_next = |trap_pend_next && (trap_act_next == 10'h000 ||
			top_idx(trap_pend_next) > top_idx(trap_act_next));
		trap_vec_next = top_idx(trap_pend_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 64; i++) node_reg[i] <= `ITU_RST_NODE;
			for (int c = 0; c < CHANNELS; c++) begin
				ctl_reg[c] <= `ITU_RST_CTL;
				src_reg[c] <= `ITU_RST_PTR;
				dst_reg[c] <= `ITU_RST_PTR;
			end
			eru_cfg_reg <= `ITU_RST_CFG;
			ssr_reg <= 8'h00;
			esr_cfg_reg <= 8'h00;
			ctrl_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			trap_flag_reg <= 10'h000;
			trap_pend_reg <= 10'h000;
			trap_act_reg <= 10'h000;
			trap_req_reg <= 1'b0;
			trap_vec_reg <= 4'h0;
			state_reg <= itu_pkg::S_IDLE;
			sel_reg <= 6'h00;
			lvl_reg <= 4'h0;
			cnt_reg <= 4'h0;
			sw_reg <= 1'b0;
			swp_reg <= 1'b0;
			swn_reg <= 6'h00;
		end else if (ce) begin
			node_reg <= node_next;
			ctl_reg <= ctl_next;
			src_reg <= src_next;
			dst_reg <= dst_next;
			eru_cfg_reg <= eru_cfg_next;
			ssr_reg <= ssr_next;
			esr_cfg_reg <= esr_cfg_next;
			ctrl_reg <= ctrl_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			trap_flag_reg <= trap_flag_next;
			trap_pend_reg <= trap_pend_next;
			trap_act_reg <= trap_act_next;
			trap_req_reg <= trap_req_next;
			trap_vec_reg <= trap_vec_next;
			state_reg <= state_next;
			sel_reg <= sel_next;
			lvl_reg <= lvl_next;
			cnt_reg <= cnt_next;
			sw_reg <= sw_next;
			swp_reg <= swp_next;
			swn_reg <= swn_next;
		end
	end

	assign int_req = state_reg == itu_pkg::S_REQ && !trap_busy;
	assign int_vector = sel_reg;
	assign int_level = lvl_reg;
	assign xfer_req = state_reg == itu_pkg::S_XFER && !trap_busy;
	assign xfer_src = src_reg[ch_sel];
	assign xfer_dst = dst_reg[ch_sel];
	assign xfer_word = ctl_reg[ch_sel][`ITU_CC_WORD];
	assign trap_req = trap_req_reg;
	assign trap_vector = trap_vec_reg;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_grant;
		ce && state_reg == itu_pkg::S_IDLE && state_next == itu_pkg::S_WAIT;
	endsequence
	sequence s_take;
		ce && xfer_take && !wr;
	endsequence

	a_resp_min: assert property (s_grant |=> (!int_req && !xfer_req)[*7])
		else $error("service requested before least response time");
	a_grant_prio: assert property (s_grant ##0 !swp_reg |=> lvl_reg > $past(cpu_level))
		else $error("granted node does not outrank cpu level");
	a_trap_block: assert property (trap_busy |-> !clr_en && !xfer_take && !int_req)
		else $error("service accepted or shown during trap service");
	a_xfer_single: assert property (s_take |=> !xfer_req ##1 !xfer_req)
		else $error("transfer held more than one cycle");
	a_cnt_dec: assert property (s_take ##0 !ctl_reg[ch_sel][`ITU_CC_CONT] |=>
		ctl_reg[$past(ch_sel)][`ITU_CC_CNT] == $past(ctl_reg[ch_sel][`ITU_CC_CNT]) - 8'h01)
		else $error("transfer counter not decremented");
	a_src_step: assert property (s_take ##0 ctl_reg[ch_sel][`ITU_CC_ISRC] |=>
		src_reg[$past(ch_sel)] ==
		$past(src_reg[ch_sel]) + step($past(ctl_reg[ch_sel][`ITU_CC_WORD])))
		else $error("source pointer step wrong");
	a_zero_int: assert property (ce && state_reg == itu_pkg::S_WAIT && cnt_reg == resp_last &&
		!sw_reg && sel_node[`ITU_NC_REQ] && sel_node[`ITU_NC_MODE] &&
		!ctl_reg[ch_sel][`ITU_CC_CONT] && ctl_reg[ch_sel][`ITU_CC_CNT] == 8'h00
		|=> state_reg == itu_pkg::S_REQ ##1 !xfer_req)
		else $error("exhausted channel did not raise interrupt");
	a_flag_clear: assert property (ce && clr_en && !evt[sel_reg] && !wr |=>
		!node_reg[$past(sel_reg)][`ITU_NC_REQ])
		else $error("request flag not cleared on acceptance");
	a_trap_flag: assert property (ce && |hw_trap |=>
		(trap_flag_reg[7:0] & $past(hw_trap)) == $past(hw_trap) ##1 trap_req || trap_busy)
		else $error("trap flag or trap request missing");
endmodule

// [tb/itu_cpu_model.sv]
`timescale 1ns/1ns
module itu_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] slow,
	input wire logic [2:0] req,
	output logic [2:0] ack
);
	logic [3:0] cnt [3];
	// Ack drops right after one cycle so a held request is never accepted twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack <= 3'h0;
			for (int k = 0; k < 3; k++) cnt[k] <= 4'h0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (ack[k] || req[k] !== 1'b1) begin
					ack[k] <= 1'b0;
					cnt[k] <= 4'h0;
				end else if (cnt[k] >= slow) begin
					ack[k] <= 1'b1;
				end else begin
					cnt[k] <= cnt[k] + 4'h1;
				end
			end
		end
	end
endmodule

// [tb/itu_top_tb.sv]
`timescale 1ns/1ns
module itu_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, int_req, xfer_req, trap_req, xfer_word;
	logic [63:0] src_evt = '0;
	logic [15:0] shared_src = '0;
	logic [3:0] eru_pin = 4'h0;
	logic [2:0] esr_pin = 3'h0;
	logic [7:0] hw_trap = 8'h00;
	logic [3:0] cpu_level = 4'h0;
	logic [5:0] int_vector;
	logic [3:0] int_level;
	logic [3:0] trap_vector;
	logic [15:0] xfer_src;
	logic [15:0] xfer_dst;
	logic trap_done = 1'b0;
	logic swtrap_valid = 1'b0;
	logic [5:0] swtrap_num = 6'h00;
	logic [3:0] slow = 4'h0;
	logic [2:0] reqs;
	logic [2:0] acks;
	int fail_count = 0;
	int checked = 0;
	assign reqs = {trap_req, xfer_req, int_req};
	always #5 pclk = ~pclk;

	itu_top #(.CHANNELS(8), .PTR_W(16)) itu_top_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_evt(src_evt), .shared_src(shared_src),
		.eru_pin(eru_pin), .esr_pin(esr_pin), .hw_trap(hw_trap), .cpu_level(cpu_level),
		.int_req(int_req), .int_vector(int_vector), .int_level(int_level),
		.int_ack(acks[0]), .xfer_req(xfer_req), .xfer_src(xfer_src),
		.xfer_dst(xfer_dst), .xfer_word(xfer_word), .xfer_ack(acks[1]),
		.trap_req(trap_req), .trap_vector(trap_vector), .trap_ack(acks[2]),
		.trap_done(trap_done), .swtrap_valid(swtrap_valid), .swtrap_num(swtrap_num)
	);
	itu_cpu_model itu_cpu_model_inst (
		.pclk(pclk), .presetn(presetn), .slow(slow), .req(reqs), .ack(acks)
	);

	task automatic complete_run();
		if (fail_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk(nm, exp, q);
	endtask

	// Returns on the edge that samples the pulse, so latencies count from there
	task automatic pls(input int w, input int i);
		@(posedge pclk);
		case (w)
			0: src_evt[i] <= 1'b1;
			1: shared_src[i] <= 1'b1;
			2: hw_trap[i] <= 1'b1;
			3: trap_done <= 1'b1;
			default: begin
				swtrap_num <= 6'(i);
				swtrap_valid <= 1'b1;
			end
		endcase
		@(posedge pclk);
		src_evt <= '0;
		shared_src <= '0;
		hw_trap <= 8'h00;
		trap_done <= 1'b0;
		swtrap_valid <= 1'b0;
	endtask

	// Gives up after 60 edges; n then reads 60, which marks an absent request
	task automatic wait_lvl(input int k, input logic v, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (reqs[k] !== v && n < 60);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rdc("node0", 12'h000, 32'h0000_0000);
		wr(12'h0FC, 32'h0000_03FE);
		rdc("node63", 12'h0FC, 32'h0000_03FE);
		wr(12'h0FC, 32'h0000_0000);
		apb(1'b0, 12'h400, 32'h0000_0000, q, e);
		chk("unmapped err", 32'h0000_0001, 32'(e));
		chk("unmapped data", 32'h0000_0000, q);
	endtask

	task automatic t_latency();
		int n;
		for (int jc = 0; jc < 2; jc++) begin
			wr(12'h388, 32'(jc));
			wr(12'h014, 32'h0000_000E);
			pls(0, 5);
			wait_lvl(0, 1'b1, n);
			chk("latency", jc ? 32'h0000_0008 : 32'h0000_000C, 32'(n));
			chk("vector", 32'h0000_0005, 32'(int_vector));
			chk("level", 32'h0000_0003, 32'(int_level));
			wait_lvl(0, 1'b0, n);
			rdc("flag clr", 12'h014, 32'h0000_000E);
		end
	endtask

	task automatic t_prio();
		int n;
		slow <= 4'h2;
		cpu_level <= 4'hF;
		wr(12'h008, 32'h0000_000B);
		wr(12'h024, 32'h0000_001F);
		wr(12'h010, 32'h0000_0007);
		cpu_level <= 4'h1;
		wait_lvl(0, 1'b1, n);
		chk("first", 32'h0000_0009, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
		wait_lvl(0, 1'b1, n);
		chk("second", 32'h0000_0002, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
		wait_lvl(0, 1'b1, n);
		chk("not above", 32'h0000_003C, 32'(n));
		cpu_level <= 4'h0;
		wait_lvl(0, 1'b1, n);
		chk("third", 32'h0000_0004, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
		slow <= 4'h0;
	endtask

	task automatic t_xfer();
		int n;
		wr(12'h230, 32'h0000_0302);
		wr(12'h234, 32'h0000_1000);
		wr(12'h238, 32'h0000_2000);
		wr(12'h030, 32'h0000_01D2);
		for (int i = 0; i < 2; i++) begin
			pls(0, 12);
			wait_lvl(1, 1'b1, n);
			chk("src", 32'h0000_1000 + 32'(2 * i), 32'(xfer_src));
			chk("dst", 32'h0000_2000, 32'(xfer_dst));
			chk("word", 32'h0000_0001, 32'(xfer_word));
			wait_lvl(1, 1'b0, n);
			chk("stolen", 32'h0000_0002, 32'(n));
		end
		pls(0, 12);
		wait_lvl(0, 1'b1, n);
		chk("cnt zero", 32'h0000_000C, 32'(int_vector));
		chk("no xfer", 32'h0000_0000, 32'(xfer_req));
		wait_lvl(0, 1'b0, n);
		rdc("src ptr", 12'h234, 32'h0000_1004);
		rdc("dst ptr", 12'h238, 32'h0000_2000);
		rdc("count", 12'h230, 32'h0000_0300);
		wr(12'h200, 32'h0000_0C00);
		wr(12'h208, 32'h0000_0010);
		wr(12'h034, 32'h0000_0052);
		for (int i = 0; i < 2; i++) begin
			pls(0, 13);
			wait_lvl(1, 1'b1, n);
			chk("byte", 32'h0000_0010 + 32'(i), 32'(xfer_dst));
			wait_lvl(1, 1'b0, n);
		end
		rdc("cont cnt", 12'h200, 32'h0000_0C00);
		rdc("byte dst", 12'h208, 32'h0000_0012);
	endtask

	task automatic t_trap();
		int n;
		pls(2, 2);
		wait_lvl(2, 1'b1, n);
		chk("trap at", 32'h0000_0001, 32'(n));
		chk("trap vec", 32'h0000_0002, 32'(trap_vector));
		pls(0, 5);
		wait_lvl(0, 1'b1, n);
		chk("int held", 32'h0000_003C, 32'(n));
		pls(2, 5);
		wait_lvl(2, 1'b1, n);
		chk("nest vec", 32'h0000_0005, 32'(trap_vector));
		rdc("flags", 12'h380, 32'h0000_0024);
		wr(12'h380, 32'h0000_0024);
		rdc("flags clr", 12'h380, 32'h0000_0000);
		pls(3, 0);
		pls(3, 0);
		wait_lvl(0, 1'b1, n);
		chk("int after", 32'h0000_0005, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
	endtask

	task automatic t_esr();
		int n;
		for (int g = 0; g < 2; g++) begin
			wr(12'h384, g ? 32'h0000_0002 : 32'h0000_0010);
			@(posedge pclk);
			esr_pin[g] <= 1'b1;
			wait_lvl(2, 1'b1, n);
			chk("sysreq", g ? 32'h0000_0008 : 32'h0000_0009, 32'(trap_vector));
			wait_lvl(2, 1'b0, n);
			pls(3, 0);
			esr_pin <= 3'h0;
		end
	endtask

	task automatic t_eru();
		int n;
		wr(12'h0E0, 32'h0000_0016);
		wr(12'h300, 32'h0001_0002);
		eru_pin[0] <= 1'b1;
		wait_lvl(0, 1'b1, n);
		chk("rise ignored", 32'h0000_003C, 32'(n));
		eru_pin[0] <= 1'b0;
		wait_lvl(0, 1'b1, n);
		chk("fall", 32'h0000_0038, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
		eru_pin[1] <= 1'b1;
		wr(12'h300, 32'h0202_0003);
		rdc("status", 12'h304, 32'h0000_0012);
		eru_pin[0] <= 1'b1;
		wait_lvl(0, 1'b1, n);
		chk("match", 32'h0000_0038, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
		wr(12'h300, 32'h0203_0003);
		eru_pin[0] <= 1'b0;
		wait_lvl(0, 1'b1, n);
		chk("miss block", 32'h0000_003C, 32'(n));
		eru_pin <= 4'h0;
	endtask

	task automatic t_shared();
		int n;
		wr(12'h100, 32'h0000_0002);
		wr(12'h0F0, 32'h0000_001A);
		pls(1, 1);
		wait_lvl(0, 1'b1, n);
		chk("unselected", 32'h0000_003C, 32'(n));
		pls(1, 2);
		wait_lvl(0, 1'b1, n);
		chk("selected", 32'h0000_003C, 32'(int_vector));
		wait_lvl(0, 1'b0, n);
	endtask

	task automatic t_swtrap();
		int n;
		cpu_level <= 4'h2;
		pls(4, 33);
		wait_lvl(0, 1'b1, n);
		chk("sw vec", 32'h0000_0021, 32'(int_vector));
		chk("sw lvl", 32'h0000_0002, 32'(int_level));
		wait_lvl(0, 1'b0, n);
		cpu_level <= 4'h0;
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_latency();
		t_prio();
		t_xfer();
		t_trap();
		t_esr();
		t_eru();
		t_shared();
		t_swtrap();
		complete_run();
	end

	// Whole sequence needs well under a thousand cycles; this bound only catches a hang
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		complete_run();
	end
endmodule
